// File: logic/tvu_regs.svh
`ifndef TVU_REGS_SVH
`define TVU_REGS_SVH

// register word offsets on the plain register port
`define TVU_ADDR_W 8
`define TVU_DATA_W 16
`define TVU_OFF_TRAP_FLAG 8'h00
`define TVU_OFF_VEC_SEG 8'h04
`define TVU_OFF_CPU_CTRL1 8'h08
`define TVU_OFF_EVT_STAT 8'h0c
`define TVU_OFF_EVT_MASK 8'h10
`define TVU_OFF_SVC_LEVEL 8'h14

// reset values
`define TVU_RST_VEC_SEG 8'h00
`define TVU_RST_SPACING 2'h0
`define TVU_RST_MASK 3'h0

// spacing field in cpu_control_register_1
`define TVU_SPACING_LSB 0
`define TVU_SPACING_MSB 1
// spacing code 0 gives 4 bytes, i.e. a shift of 2
`define TVU_SPACING_BASE_SHIFT 3'h2

// trap flag bit positions
`define TVU_FLAG_SR0 0
`define TVU_FLAG_STACK_OVERFLOW_FLAG 1
`define TVU_FLAG_STACK_UNDERFLOW_FLAG 2
`define TVU_FLAG_SWBRK 3
`define TVU_FLAG_SR1 4
`define TVU_FLAG_UNDEFINED_OPCODE_FLAG 5
`define TVU_FLAG_ACCERR 6
`define TVU_FLAG_PROT 7
`define TVU_FLAG_ILLOP 8
`define TVU_NUM_FLAGS 9

// trap numbers
`define TVU_TN_RESET 7'h00
`define TVU_TN_SR0 7'h02
`define TVU_TN_STACK_OVERFLOW_FLAG 7'h04
`define TVU_TN_STACK_UNDERFLOW_FLAG 7'h06
`define TVU_TN_SWBRK 7'h08
`define TVU_TN_CLASS_B 7'h0a

// event status bit positions
`define TVU_EVT_CLASS_A 0
`define TVU_EVT_CLASS_B 1
`define TVU_EVT_SW_TRAP 2

// service level stack depth
`define TVU_STK_DEPTH 4

`endif

// File: logic/tvu_pkg.sv
package tvu_pkg;
	`include "tvu_regs.svh"

	typedef enum logic [1:0] {
		TVU_LVL_NONE = 2'h0,
		TVU_LVL_B = 2'h1,
		TVU_LVL_A = 2'h2,
		TVU_LVL_RESET = 2'h3
	} tvu_level_e;

	// gray along boot -> run
	typedef enum logic [1:0] {
		TVU_ST_BOOT = 2'b00,
		TVU_ST_RUN = 2'b01
	} tvu_state_e;

	typedef struct packed {
		logic illegal_word_operand_flag;
		logic protected_instruction_fault_flag;
		logic memory_access_error_flag;
		logic undefined_opcode_flag;
		logic system_request_1_flag;
		logic software_break_flag;
		logic stack_underflow_flag;
		logic stack_overflow_flag;
		logic system_request_0_flag;
	} tvu_hw_trap_s;

	typedef struct packed {
		logic valid;
		tvu_level_e level;
		logic [6:0] trap_num;
		logic [7:0] segment;
		logic [15:0] offset;
	} tvu_branch_s;
endpackage : tvu_pkg

// File: logic/tvu_trap_vector_unit.sv
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps
// Contract
// - every class A hardware trap forces a branch to its own vector, class B to the shared one; no mask can stop it.
// - every hardware trap sets its own bit in the trap flag register.
// - a hardware trap preempts execution unless a higher-priority trap service runs.
// - during a hardware trap service, interrupts and event controller transfers wait.
// - class A traps go to 0008/02, 0010/04, 0018/06 and 0020/08.
// - all class B traps share vector 0028 with number 0A and differ only by flags.
// - a software trap takes any number 00 to 7F and keeps the current priority.
// - the vector segment register supplies the upper address of every vector.
// - vector spacing comes from the spacing field, default 4 bytes.
// - serial 2 channel 1 nodes use 5F to 61; nodes 62 to 6A are unassigned.
// - end of subchannel node uses 6F; system, flash and clock nodes take 6B to 6E.
module tvu_trap_vector_unit
	import tvu_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// register port
	input wire logic [`TVU_ADDR_W-1:0] reg_addr,
	input wire logic [`TVU_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [`TVU_DATA_W-1:0] reg_rdata,
	// trap sources
	input wire tvu_hw_trap_s hw_trap,
	input wire logic sw_trap_req,
	input wire logic [6:0] sw_trap_num,
	input wire logic int_req,
	input wire logic [6:0] int_num,
	input wire logic pec_req,
	// cpu pipeline side
	input wire logic svc_return,
	output tvu_branch_s branch,
	output logic sw_trap_ack,
	output logic int_ack,
	output logic pec_grant,
	// event interrupt
	output logic irq
);

	// reset release synchroniser
	logic rst_meta_reg;
	logic rst_sync_reg;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	wire logic rst_i_n = rst_sync_reg;

	// state
	tvu_state_e state_reg;
	tvu_level_e lvl_reg;
	tvu_level_e lvl_next;
	tvu_level_e stk_reg [`TVU_STK_DEPTH];
	logic [`TVU_NUM_FLAGS-1:0] flag_reg;
	logic [`TVU_NUM_FLAGS-1:0] pend_reg;
	logic [7:0] seg_reg;
	logic [1:0] spacing_reg;
	logic [2:0] stat_reg;
	logic [2:0] mask_reg;

	// register write decode
	wire logic wr_flag = reg_wr && (reg_addr == `TVU_OFF_TRAP_FLAG);
	wire logic wr_seg = reg_wr && (reg_addr == `TVU_OFF_VEC_SEG);
	wire logic wr_ctrl = reg_wr && (reg_addr == `TVU_OFF_CPU_CTRL1);
	wire logic wr_stat = reg_wr && (reg_addr == `TVU_OFF_EVT_STAT);
	wire logic wr_mask = reg_wr && (reg_addr == `TVU_OFF_EVT_MASK);

	// raw hardware events, one bit per trap source
	wire logic [`TVU_NUM_FLAGS-1:0] hw_evt = hw_trap;

	// pending split into class A (low four) and class B (upper five)
	wire logic [3:0] pend_a = pend_reg[`TVU_FLAG_SWBRK:`TVU_FLAG_SR0];
	wire logic [4:0] pend_b = pend_reg[`TVU_FLAG_ILLOP:`TVU_FLAG_SR1];
	wire logic any_a = |pend_a;
	wire logic any_b = |pend_b;
	wire logic running = (state_reg == TVU_ST_RUN);

	// a return in the same cycle as a dispatch pops first, so no return is lost
	wire logic ret_now = running && svc_return;
	wire tvu_level_e cur_lvl = ret_now ? stk_reg[0] : lvl_reg;

	// class A is never masked; equal level may nest, only the reset service blocks it
	wire logic take_a = running && any_a && (cur_lvl != TVU_LVL_RESET);
	wire logic take_b = running && !any_a && any_b && (cur_lvl <= TVU_LVL_B);
	wire logic hw_wait = any_a || any_b;
	// a waiting hardware trap also holds off software traps and interrupts
	wire logic take_sw = running && !hw_wait && sw_trap_req;
	wire logic take_int = running && !hw_wait && !sw_trap_req && int_req &&
		(cur_lvl == TVU_LVL_NONE);
	wire logic take_pec = running && pec_req && !hw_wait &&
		(cur_lvl == TVU_LVL_NONE);

	// class A number by fixed order within the class
	wire logic [6:0] num_a = pend_a[0] ? `TVU_TN_SR0 :
		pend_a[1] ? `TVU_TN_STACK_OVERFLOW_FLAG :
		pend_a[2] ? `TVU_TN_STACK_UNDERFLOW_FLAG : `TVU_TN_SWBRK;
	// one clear mask for the class A bit served
	wire logic [3:0] clr_a = pend_a[0] ? 4'h1 :
		pend_a[1] ? 4'h2 :
		pend_a[2] ? 4'h4 : 4'h8;

	// trap number of whatever is dispatched this cycle
	wire logic [6:0] disp_num = !running ? `TVU_TN_RESET :
		take_a ? num_a :
		take_b ? `TVU_TN_CLASS_B :
		take_sw ? sw_trap_num : int_num;
	wire logic dispatch = !running || take_a || take_b || take_sw || take_int;

	// offset = number shifted by log2 of spacing
	wire logic [2:0] shamt = `TVU_SPACING_BASE_SHIFT + {1'b0, spacing_reg};
	wire logic [15:0] disp_off = {9'h00, disp_num} << shamt;

	// level after this cycle: hardware raises it, software trap keeps it
	always_comb begin
		lvl_next = cur_lvl;
		if (!running) begin
			lvl_next = TVU_LVL_RESET;
		end else if (take_a) begin
			lvl_next = TVU_LVL_A;
		end else if (take_b) begin
			lvl_next = TVU_LVL_B;
		end else if (take_sw || take_int) begin
			lvl_next = cur_lvl;
		end
	end

	// boot issues the reset branch once, then runs
	tvu_state_e state_next;
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			TVU_ST_BOOT: begin
				state_next = TVU_ST_RUN;
			end
			TVU_ST_RUN: begin
				state_next = TVU_ST_RUN;
			end
			default: begin
				state_next = TVU_ST_BOOT;
			end
		endcase
	end

	// the internal reset copy holds boot until two edges after release
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= TVU_ST_BOOT;
		end else if (!rst_i_n) begin
			state_reg <= TVU_ST_BOOT;
		end else begin
			state_reg <= state_next;
		end
	end

	// service level with a small return stack; deep nesting drops the oldest entry
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			lvl_reg <= TVU_LVL_RESET;
			for (int i = 0; i < `TVU_STK_DEPTH; i++) begin
				stk_reg[i] <= TVU_LVL_NONE;
			end
		end else begin
			lvl_reg <= lvl_next;
			if (running && dispatch && !ret_now) begin
				stk_reg[0] <= lvl_reg;
				for (int i = 1; i < `TVU_STK_DEPTH; i++) begin
					stk_reg[i] <= stk_reg[i-1];
				end
			end else if (running && dispatch) begin
				// pop and push cancel out, the restored level stays on top
				stk_reg[0] <= cur_lvl;
			end else if (ret_now) begin
				for (int i = 0; i < `TVU_STK_DEPTH - 1; i++) begin
					stk_reg[i] <= stk_reg[i+1];
				end
				stk_reg[`TVU_STK_DEPTH-1] <= TVU_LVL_NONE;
			end
		end
	end

	// which pending bits the current dispatch consumes: one class A bit or every class B bit
	wire logic [`TVU_NUM_FLAGS-1:0] pend_clr = take_a ? {5'h00, clr_a} :
		take_b ? {pend_b, 4'h0} : {`TVU_NUM_FLAGS{1'b0}};

	// pending traps; a new event wins over the dispatch clear
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pend_reg <= '0;
		end else begin
			pend_reg <= (pend_reg & ~pend_clr) | hw_evt;
		end
	end

	// visible flags, write one to clear; software may miss nothing, so set wins
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			flag_reg <= '0;
		end else begin
			flag_reg <= (flag_reg & ~(wr_flag ? reg_wdata[`TVU_NUM_FLAGS-1:0] :
				{`TVU_NUM_FLAGS{1'b0}})) | hw_evt;
		end
	end

	// vector segment, relocates the whole table at once
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			seg_reg <= `TVU_RST_VEC_SEG;
		end else if (wr_seg) begin
			seg_reg <= reg_wdata[7:0];
		end
	end

	// vector spacing; a change mid-run moves every later vector
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			spacing_reg <= `TVU_RST_SPACING;
		end else if (wr_ctrl) begin
			spacing_reg <= reg_wdata[`TVU_SPACING_MSB:`TVU_SPACING_LSB];
		end
	end

	// event mask gates only the irq line, never a trap
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mask_reg <= `TVU_RST_MASK;
		end else if (wr_mask) begin
			mask_reg <= reg_wdata[2:0];
		end
	end

	// sticky event status, write one to clear, set wins
	wire logic [2:0] evt_set = {take_sw, take_b, take_a};
	wire logic [2:0] evt_clr = wr_stat ? reg_wdata[2:0] : 3'h0;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stat_reg <= 3'h0;
			irq <= 1'b0;
		end else begin
			stat_reg <= (stat_reg & ~evt_clr) | evt_set;
			irq <= |(((stat_reg & ~evt_clr) | evt_set) & mask_reg);
		end
	end

	// branch request toward the pipeline; only valid is a pulse
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			branch <= '0;
		end else begin
			branch.valid <= rst_i_n && dispatch;
			branch.level <= lvl_next;
			branch.trap_num <= disp_num;
			branch.segment <= seg_reg;
			branch.offset <= disp_off;
		end
	end

	// acknowledges; a source not acknowledged keeps its request up
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sw_trap_ack <= 1'b0;
			int_ack <= 1'b0;
			pec_grant <= 1'b0;
		end else begin
			sw_trap_ack <= take_sw;
			int_ack <= take_int;
			pec_grant <= take_pec;
		end
	end

	// read mux; unmapped addresses read zero
	logic [`TVU_DATA_W-1:0] rd_mux;
	always_comb begin
		rd_mux = 16'h0000;
		if (reg_addr == `TVU_OFF_TRAP_FLAG) begin
			rd_mux = {7'h00, flag_reg};
		end else if (reg_addr == `TVU_OFF_VEC_SEG) begin
			rd_mux = {8'h00, seg_reg};
		end else if (reg_addr == `TVU_OFF_CPU_CTRL1) begin
			rd_mux = {14'h0000, spacing_reg};
		end else if (reg_addr == `TVU_OFF_EVT_STAT) begin
			rd_mux = {13'h0000, stat_reg};
		end else if (reg_addr == `TVU_OFF_EVT_MASK) begin
			rd_mux = {13'h0000, mask_reg};
		end else if (reg_addr == `TVU_OFF_SVC_LEVEL) begin
			rd_mux = {14'h0000, lvl_reg};
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 16'h0000;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : 16'h0000;
		end
	end

endmodule : tvu_trap_vector_unit

// File: dv/tvu_chk.sv
`timescale 1ns/1ps
module tvu_chk
	import tvu_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	// trap sources
	input wire tvu_hw_trap_s hw_trap,
	input wire logic [6:0] sw_trap_num,
	input wire logic [6:0] int_num,
	// cpu side
	input wire logic svc_return,
	input wire tvu_branch_s branch,
	input wire logic sw_trap_ack,
	input wire logic int_ack,
	input wire logic pec_grant
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic [7:0] seg_reg;
	logic [1:0] spc_reg;
	logic rsvc_reg;
	// shadow copies of the config registers, decoded from the bus
	wire seg_wr = reg_wr && reg_addr == 8'h04;
	wire spc_wr = reg_wr && reg_addr == 8'h08;
	wire hw_any = |hw_trap;
	wire rst_br = branch.valid && branch.level == TVU_LVL_RESET;
	// reset service blocks class a until the cpu returns from it
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			seg_reg <= 8'h00;
			spc_reg <= 2'h0;
			rsvc_reg <= 1'b0;
		end else begin
			if (seg_wr) seg_reg <= reg_wdata[7:0];
			if (spc_wr) spc_reg <= reg_wdata[1:0];
			if (svc_return) rsvc_reg <= 1'b0;
			else if (rst_br) rsvc_reg <= 1'b1;
		end
	end
	sequence s_reset_vec;
		branch.valid && branch.trap_num == 7'h00 && branch.offset == 16'h0000 && rst_br;
	endsequence
	sequence s_class_a_hit;
		(|hw_trap[3:0]) && !rsvc_reg;
	endsequence
	a_reset_vector: assert property ($rose(rst_n) |-> ##[1:5] s_reset_vec)
		else $error("reset branch missing");
	a_offset_calc: assert property (branch.valid |->
		branch.offset == ({9'h000, branch.trap_num} << (2 + spc_reg)))
		else $error("vector offset wrong");
	a_segment_src: assert property (branch.valid |-> branch.segment == seg_reg)
		else $error("vector segment wrong");
	a_class_a_vec: assert property (branch.valid && branch.level == TVU_LVL_A |->
		branch.trap_num inside {7'h02, 7'h04, 7'h06, 7'h08})
		else $error("class a number wrong");
	a_class_b_vec: assert property (branch.valid && branch.level == TVU_LVL_B |->
		branch.trap_num == 7'h0a)
		else $error("class b number wrong");
	a_hw_preempt: assert property (s_class_a_hit |->
		##[2:8] (branch.valid && branch.level == TVU_LVL_A))
		else $error("class a trap not taken");
	a_int_hold: assert property (int_ack |-> !$past(hw_any, 2))
		else $error("interrupt beat hw trap");
	a_pec_hold: assert property (pec_grant |-> !$past(hw_any, 2))
		else $error("event transfer beat hw trap");
	a_sw_vector: assert property (sw_trap_ack |->
		branch.valid && branch.trap_num == $past(sw_trap_num))
		else $error("software trap number wrong");
	a_int_vector: assert property (int_ack |->
		branch.valid && branch.trap_num == $past(int_num))
		else $error("interrupt number wrong");
endmodule : tvu_chk

// File: dv/tvu_cpu_model.sv
`timescale 1ns/1ps
module tvu_cpu_model
	import tvu_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// branch side
	input wire tvu_branch_s branch,
	input wire logic svc_en,
	input wire logic [3:0] svc_delay,
	output logic svc_return
);
	int open_cnt;
	int wait_cnt;
	// every taken branch opens a service that returns after svc_delay cycles
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			open_cnt = 0;
			wait_cnt = 0;
			svc_return <= 1'b0;
		end else begin
			svc_return <= 1'b0;
			if (branch.valid) open_cnt = open_cnt + 1;
			if (open_cnt > 0 && svc_en) begin
				if (wait_cnt >= svc_delay) begin
					svc_return <= 1'b1;
					open_cnt = open_cnt - 1;
					wait_cnt = 0;
				end else wait_cnt = wait_cnt + 1;
			end
		end
	end
endmodule : tvu_cpu_model

// File: dv/tvu_tb.sv
`timescale 1ns/1ps
module testbench
	import tvu_pkg::*;
;
	logic clk_sys, rst_n, reg_wr, reg_rd, sw_trap_req, int_req, pec_req, svc_return;
	logic sw_trap_ack, int_ack, pec_grant, irq, svc_en;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	logic [6:0] sw_trap_num, int_num;
	logic [3:0] svc_delay;
	tvu_hw_trap_s hw_trap;
	tvu_branch_s branch;
	int n_fail, cmp_count;
	tvu_trap_vector_unit dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.hw_trap(hw_trap), .sw_trap_req(sw_trap_req), .sw_trap_num(sw_trap_num),
		.int_req(int_req), .int_num(int_num), .pec_req(pec_req), .svc_return(svc_return),
		.branch(branch), .sw_trap_ack(sw_trap_ack), .int_ack(int_ack),
		.pec_grant(pec_grant), .irq(irq));
	tvu_cpu_model cpu_u (.clk_sys(clk_sys), .rst_n(rst_n), .branch(branch), .svc_en(svc_en),
		.svc_delay(svc_delay), .svc_return(svc_return));
	always #10 clk_sys = ~clk_sys;
	task print_verdict();
		$display("checks %0d fails %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// bounded wait for a branch pulse; a timeout ends the run
	task wait_br();
		int i;
		i = 0;
		do begin
			@(posedge clk_sys);
			#1;
			i++;
		end while (branch.valid !== 1'b1 && i < 40);
		if (branch.valid !== 1'b1) begin
			chk(0, 1);
			print_verdict();
		end
	endtask : wait_br
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask : rd
	task hw(input logic [8:0] v);
		@(posedge clk_sys);
		hw_trap <= tvu_hw_trap_s'(v);
		@(posedge clk_sys);
		hw_trap <= '0;
		wait_br();
	endtask : hw
	// request held until the branch shows, dropped off the edge
	task go(input logic is_int, input logic [6:0] n);
		@(posedge clk_sys);
		if (is_int) begin
			int_num <= n;
			int_req <= 1'b1;
		end else begin
			sw_trap_num <= n;
			sw_trap_req <= 1'b1;
		end
		wait_br();
		int_req <= 1'b0;
		sw_trap_req <= 1'b0;
		chk(is_int ? int_ack : sw_trap_ack, 1);
	endtask : go
	// class a traps one by one with a slow cpu return
	task t_class_a();
		svc_delay <= 4'h5;
		for (int k = 0; k < 4; k++) begin
			hw(9'(1 << k));
			chk(branch.trap_num, 2 * k + 2);
			chk(branch.offset, (2 * k + 2) * 4);
			rd(8'h00, 16'(1 << k));
			wr(8'h00, 16'h01ff);
		end
		svc_delay <= 4'h0;
		repeat (20) @(posedge clk_sys);
	endtask : t_class_a
	// irq raise and clear, then all class b at once under a mask
	task t_events();
		wr(8'h0c, 16'h0007);
		wr(8'h10, 16'h0001);
		hw(9'h001);
		@(posedge clk_sys);
		#1 chk(irq, 1);
		wr(8'h0c, 16'h0007);
		@(posedge clk_sys);
		#1 chk(irq, 0);
		hw(9'h1f0);
		chk({branch.trap_num, branch.offset}, {7'h0a, 16'h0028});
		@(posedge clk_sys);
		#1 chk(irq, 0);
		rd(8'h00, 16'h01f1);
		rd(8'h0c, 16'h0002);
		rd(8'h40, 16'h0000);
		wr(8'h00, 16'h01ff);
		wr(8'h0c, 16'h0007);
		repeat (10) @(posedge clk_sys);
	endtask : t_events
	// relocated table and wide spacing, then interrupt nodes
	task t_reloc();
		logic [6:0] nn [3];
		logic [15:0] oo [3];
		nn = '{7'h5f, 7'h6f, 7'h6b};
		oo = '{16'h017c, 16'h01bc, 16'h01ac};
		wr(8'h04, 16'h005a);
		wr(8'h08, 16'h0001);
		rd(8'h04, 16'h005a);
		go(1'b0, 7'h7f);
		chk({branch.segment, branch.offset}, {8'h5a, 16'h03f8});
		wr(8'h08, 16'h0000);
		for (int k = 0; k < 3; k++) begin
			go(1'b1, nn[k]);
			chk(branch.offset, oo[k]);
		end
	endtask : t_reloc
	// interrupt and event transfer wait behind an open hw service
	task t_block();
		svc_en <= 1'b0;
		hw(9'h002);
		int_num <= 7'h60;
		int_req <= 1'b1;
		pec_req <= 1'b1;
		repeat (6) begin
			@(posedge clk_sys);
			#1 chk({int_ack, pec_grant}, 0);
		end
		svc_en <= 1'b1;
		wait_br();
		int_req <= 1'b0;
		pec_req <= 1'b0;
		chk({int_ack, pec_grant, branch.offset}, {1'b1, 1'b1, 16'h0180});
	endtask : t_block
	initial begin
		{clk_sys, rst_n, reg_wr, reg_rd, sw_trap_req, int_req, pec_req} = '0;
		{reg_addr, reg_wdata, sw_trap_num, int_num, svc_delay} = '0;
		hw_trap = '0;
		svc_en = 1'b1;
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		wait_br();
		chk({branch.trap_num, branch.level}, {7'h00, TVU_LVL_RESET});
		repeat (4) @(posedge clk_sys);
		t_class_a();
		t_events();
		t_reloc();
		t_block();
		repeat (10) @(posedge clk_sys);
		print_verdict();
	end
endmodule : testbench
bind tvu_trap_vector_unit tvu_chk chk_u (.clk_sys(clk_sys), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .hw_trap(hw_trap),
	.sw_trap_num(sw_trap_num), .int_num(int_num), .svc_return(svc_return), .branch(branch),
	.sw_trap_ack(sw_trap_ack), .int_ack(int_ack), .pec_grant(pec_grant));
